// ===== verilog/alc_pkg.sv
// Purpose: constants and types for the ambient light comparator block
// Assumes: 10 MHz clock, 8-bit register port, 8-bit sensor codes
// Notes: two channels share the trip levels
// Overview of operation
// - channel a code in bits 7:5 picks filter period, 80 ms doubling to 10,240 ms.
// - bit 4 write starts channel a read when sinks run, backlight off.
// - read request bit clears itself once conversion leaves both results valid.
// - read request ignored while backlight enabled; no extra conversion.
// - channel a dark result in bit 3, office result in bit 2.
// - channel a bit 1 enables dark comparator.
// - channel a bit 0 enables office comparator.
// - dark result takes precedence over office result.
// - channel b bits 7:5 pick its filter period with same codes.
// - channel b bit 4 forced read, same conditions, self-clears, ignored if lit.
// - channel b dark result in bit 3, office result in bit 2.
// - channel b bit 1 enables dark, bit 0 enables office comparator.
// - input below office level trips office, backlight to office level.
// - input above office level plus hysteresis returns to daylight level.
// - input below dark level trips dark, backlight to dark level.
package alc_pkg;
	localparam int ALC_CLK_HZ = 10_000_000;
	localparam int ALC_BASE_PERIOD_MS = 80;
	localparam int ALC_BASE_CYCLES = ALC_BASE_PERIOD_MS * (ALC_CLK_HZ / 1000);
	localparam int ALC_TIMER_W = 27;
	localparam logic [7:0] ALC_ADDR_CFG_A = 8'h1b;
	localparam logic [7:0] ALC_ADDR_CFG_B = 8'h1c;
	localparam int ALC_SENSOR_A_DEBOUNCE_PERIOD_LSB = 5;
	localparam int ALC_FORCE_BIT = 4;
	localparam int ALC_DARK_RES_BIT = 3;
	localparam int ALC_OFFICE_RES_BIT = 2;
	localparam int ALC_DARK_ON_BIT = 1;
	localparam int ALC_OFFICE_ON_BIT = 0;
	localparam logic [7:0] ALC_CFG_RESET = 8'h00;

	typedef enum logic [1:0] {
		ALC_DAYLIGHT,
		ALC_OFFICE,
		ALC_DARK
	} alc_level_type;

	typedef struct packed {
		logic [2:0] period;
		logic force_rd;
		logic dark_res;
		logic office_res;
		logic dark_on;
		logic office_on;
	} alc_cfg_type;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} alc_req_type;

	typedef struct packed {
		logic [7:0] level;
		logic [7:0] hyst;
		logic [7:0] dark;
	} alc_trip_type;

	typedef struct packed {
		alc_cfg_type cfg;
		logic [ALC_TIMER_W-1:0] timer;
		logic [7:0] sync1;
		logic [7:0] sync2;
		alc_level_type level;
	} alc_chan_type;

	typedef struct packed {
		alc_chan_type [1:0] ch;
		logic [7:0] rdata;
	} alc_state_type;
endpackage

// ===== verilog/alc_top.sv
// Purpose: configuration, forced reads and comparators for two light inputs
// Assumes: light inputs are pin-side codes, synchronised here
// Notes: register reads return one cycle after the address is presented
`timescale 1ns/1ps
module alc_top #(
	parameter int BASE_CYCLES = alc_pkg::ALC_BASE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire alc_pkg::alc_req_type req,
	output logic [7:0] rdata,
	// sensor pins
	input wire logic [7:0] light_input_a,
	input wire logic [7:0] light_input_b,
	// system status and trip levels
	input wire logic backlight_on,
	input wire logic sinks_running,
	input wire alc_pkg::alc_trip_type trip,
	// resulting backlight level per channel
	output alc_pkg::alc_level_type level_a,
	output alc_pkg::alc_level_type level_b
);
	import alc_pkg::*;

	alc_state_type state_q;
	alc_state_type state_d;

	function automatic logic [7:0] cfg_byte(input alc_cfg_type c);
		cfg_byte = {c.period, c.force_rd, c.dark_res, c.office_res,
			c.dark_on, c.office_on};
	endfunction

	function automatic logic [ALC_TIMER_W-1:0] period_cycles(
		input logic [2:0] code);
		logic [ALC_TIMER_W-1:0] base;
		base = ALC_TIMER_W'(BASE_CYCLES);
		period_cycles = base << code;
	endfunction

	logic [1:0][7:0] pins;
	assign pins[0] = light_input_a;
	assign pins[1] = light_input_b;

	always_comb begin
		logic [8:0] upper;
		logic [7:0] smp;
		logic hit;
		logic go;
		upper = 9'(trip.level) + 9'(trip.hyst);
		smp = 8'h00;
		hit = 1'b0;
		go = 1'b0;
		state_d = state_q;
		for (int i = 0; i < 2; i++) begin
			state_d.ch[i].sync1 = pins[i];
			state_d.ch[i].sync2 = state_q.ch[i].sync1;
			smp = state_q.ch[i].sync2;
			hit = (state_q.ch[i].timer >=
				period_cycles(state_q.ch[i].cfg.period) - 1'b1);
			state_d.ch[i].timer = hit ? '0 :
				state_q.ch[i].timer + 1'b1;
			// automatic conversions only while lit; forced only while dark
			go = (hit && backlight_on) ||
				(state_q.ch[i].cfg.force_rd && !backlight_on);
			if (go) begin
				state_d.ch[i].cfg.dark_res = state_q.ch[i].cfg.dark_on &&
					(smp < trip.dark);
				if (!state_q.ch[i].cfg.office_on) begin
					state_d.ch[i].cfg.office_res = 1'b0;
				end else if (smp < trip.level) begin
					state_d.ch[i].cfg.office_res = 1'b1;
				end else if (9'(smp) > upper) begin
					state_d.ch[i].cfg.office_res = 1'b0;
				end
				// results are valid the same edge the request drops
				state_d.ch[i].cfg.force_rd = 1'b0;
			end
			if (state_d.ch[i].cfg.dark_res) begin
				state_d.ch[i].level = ALC_DARK;
			end else if (state_d.ch[i].cfg.office_res) begin
				state_d.ch[i].level = ALC_OFFICE;
			end else begin
				state_d.ch[i].level = ALC_DAYLIGHT;
			end
			if (req.wr && req.addr == (i == 0 ? ALC_ADDR_CFG_A :
				ALC_ADDR_CFG_B)) begin
				state_d.ch[i].cfg.period =
					req.wdata[ALC_SENSOR_A_DEBOUNCE_PERIOD_LSB +: 3];
				state_d.ch[i].cfg.dark_on =
					req.wdata[ALC_DARK_ON_BIT];
				state_d.ch[i].cfg.office_on =
					req.wdata[ALC_OFFICE_ON_BIT];
				// result bits untouched by writes
				// a set in the clearing cycle wins over the clear
				if (req.wdata[ALC_FORCE_BIT] && sinks_running &&
					!backlight_on) begin
					state_d.ch[i].cfg.force_rd = 1'b1;
				end
			end
		end
		case (req.addr)
			ALC_ADDR_CFG_A: state_d.rdata = cfg_byte(state_q.ch[0].cfg);
			ALC_ADDR_CFG_B: state_d.rdata = cfg_byte(state_q.ch[1].cfg);
			default: state_d.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				state_q.ch[i].cfg <= alc_cfg_type'(ALC_CFG_RESET);
				state_q.ch[i].timer <= '0;
				state_q.ch[i].sync1 <= 8'h00;
				state_q.ch[i].sync2 <= 8'h00;
				state_q.ch[i].level <= ALC_DAYLIGHT;
			end
			state_q.rdata <= 8'h00;
		end else begin
			state_q <= state_d;
		end
	end

	assign rdata = state_q.rdata;
	assign level_a = state_q.ch[0].level;
	assign level_b = state_q.ch[1].level;
endmodule

// ===== verification/alc_light_src.sv
// Purpose: phototransistor stand-in for both light inputs
// Assumes: codes are already digitised at the pins
// Notes: no settling modelled, codes follow the bench at once
`timescale 1ns/1ps
module alc_light_src (
	// wanted light
	input wire logic [7:0] want_a,
	input wire logic [7:0] want_b,
	// sensor pins
	output logic [7:0] light_input_a,
	output logic [7:0] light_input_b
);
	assign light_input_a = want_a;
	assign light_input_b = want_b;
endmodule

// ===== verification/alc_chk.sv
// Purpose: port checks for alc_top
// Assumes: no forced read is pending when lit
// Notes: bound after the module
`timescale 1ns/1ps
module alc_chk import alc_pkg::*; #(
	parameter int BASE_CYCLES = 8
) (
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire alc_req_type req,
	input wire logic [7:0] rdata,
	input wire logic backlight_on,
	input wire logic sinks_running,
	input wire alc_level_type level_a,
	input wire alc_level_type level_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rst_clears_a: assert property (disable iff (1'b0) rst |=>
		rdata == 8'h00 && level_b == ALC_DAYLIGHT) else $error("reset");
	unmapped_zero_a: assert property (req.addr != ALC_ADDR_CFG_A &&
		req.addr != ALC_ADDR_CFG_B |=> rdata == 8'h00) else $error("unmapped");
	level_a_ok_a: assert property (level_a != 2'd3) else $error("lvl a");
	level_b_ok_a: assert property (level_b != 2'd3) else $error("lvl b");
	fields_a_kept_a: assert property (req.wr &&
		req.addr == ALC_ADDR_CFG_A ##1 req.addr == ALC_ADDR_CFG_A |=>
		{rdata[7:5], rdata[1:0]} == {$past(req.wdata[7:5], 2),
		$past(req.wdata[1:0], 2)}) else $error("fields a");
	fields_b_kept_a: assert property (req.wr &&
		req.addr == ALC_ADDR_CFG_B ##1 req.addr == ALC_ADDR_CFG_B |=>
		{rdata[7:5], rdata[1:0]} == {$past(req.wdata[7:5], 2),
		$past(req.wdata[1:0], 2)}) else $error("fields b");
	lit_force_a_a: assert property (req.wr && req.wdata[4] && backlight_on &&
		req.addr == ALC_ADDR_CFG_A ##1 req.addr == ALC_ADDR_CFG_A |=>
		!rdata[4]) else $error("lit force a");
	lit_force_b_a: assert property (req.wr && req.wdata[4] && backlight_on &&
		req.addr == ALC_ADDR_CFG_B ##1 req.addr == ALC_ADDR_CFG_B |=>
		!rdata[4]) else $error("lit force b");
endmodule
bind alc_top alc_chk #(.BASE_CYCLES(BASE_CYCLES)) alc_chk_i (.clk, .rst,
	.req, .rdata, .backlight_on, .sinks_running, .level_a, .level_b);

// ===== verification/alc_top_tb_top.sv
// Purpose: self-checking bench for alc_top
// Assumes: filter base shrunk to 8 cycles
// Notes: rows hold forced reads, hand tests follow
`timescale 1ns/1ps
module alc_top_tb_top;
	import alc_pkg::*;
	typedef struct {logic [7:0] a, wd, light, rd; alc_level_type lv;} alc_row_type;
	logic clk = 0, rst = 1, lit = 0, sinks = 1;
	alc_req_type req = '0;
	logic [7:0] rdata, want = 8'h00, la, lb;
	alc_level_type level_a, level_b;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	alc_row_type rows [4] = '{'{8'h1b, 8'h13, 8'h10, 8'h0f, ALC_DARK},
		'{8'h1c, 8'h31, 8'h50, 8'h25, ALC_OFFICE},
		'{8'h1b, 8'hf1, 8'ha0, 8'he1, ALC_DAYLIGHT},
		'{8'h1c, 8'h12, 8'h10, 8'h0a, ALC_DARK}};
	alc_light_src alc_light_src_i (.want_a(want), .want_b(want),
		.light_input_a(la), .light_input_b(lb));
	alc_top #(.BASE_CYCLES(8)) alc_top_i (.clk(clk), .rst(rst), .req(req),
		.rdata(rdata), .light_input_a(la), .light_input_b(lb),
		.backlight_on(lit), .sinks_running(sinks), .trip({8'h80, 8'h10, 8'h20}),
		.level_a(level_a), .level_b(level_b));
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			fail_count++;
			wrap_up();
		end
	end
	task chk(string n, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk) req <= '{1'b1, a, d};
		@(posedge clk) req.wr <= 1'b0;
	endtask
	task rd(logic [7:0] a, logic [7:0] exp, string n);
		@(posedge clk) req.addr <= a;
		repeat (2) @(posedge clk);
		#1 chk(n, rdata, exp);
		$display("test done: %s", n);
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk) want <= rows[i].light;
			repeat (3) @(posedge clk);
			wr(rows[i].a, rows[i].wd);
			rd(rows[i].a, rows[i].rd, "row cfg");
			chk("row level", rows[i].a[0] ? level_a : level_b, rows[i].lv);
		end
		@(posedge clk) sinks <= 1'b0;
		wr(8'h1b, 8'h13);
		rd(8'h1b, 8'h03, "force without sinks");
		@(posedge clk) sinks <= 1'b1;
		wr(8'h1b, 8'h0c);
		rd(8'h1b, 8'h00, "results read-only");
		@(posedge clk) lit <= 1'b1;
		wr(8'h1b, 8'h10);
		rd(8'h1b, 8'h00, "force while lit");
		rd(8'h1d, 8'h00, "unmapped read");
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		rd(8'h1c, 8'h00, "reset state");
		wrap_up();
	end
endmodule
